/* File: rtl/silp_fifo.sv */
// Small valid/ready FIFO between storage latches and parallel drivers
`timescale 1ns/1ps
module silp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff, rd_ff;
   logic [AW:0] cnt_ff;
   logic push, pop;

   // Honest flags from the occupancy count
   assign in_ready = (cnt_ff != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (cnt_ff != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_ff[rd_ff];

   // Storage, written only on push
   always_ff @(posedge clock) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : AW'(wr_ff + 1'b1);
         end
         if (pop) begin
            rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : AW'(rd_ff + 1'b1);
         end
         cnt_ff <= (AW+1)'(cnt_ff + push - pop);
      end
   end
endmodule

/* File: rtl/silp_top.sv */
// Eight-stage shift register with storage latches and three-state outputs
// Function
// - Rising shift clock moves serial input into stage one; stages shift onward.
// - Strobe high: storage follows stages; strobe low: storage holds, outputs still take queued words.
// - Drive enable high drives the last word taken from the queue onto outputs; low leaves outputs undriven.
// - Each rising edge: stage seven passes to stage eight and rise output.
// - Each falling edge: fall output takes stage eight value.
`timescale 1ns/1ps
`include "silp_defines.svh"
module silp_top #(
   parameter int STAGES = `SILP_STAGES,
   parameter int DEPTH = `SILP_FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic serial_in,
   input wire logic shift_clock,
   input wire logic storage_load_strobe,
   input wire logic output_drive_enable,
   input wire logic drive_ready,
   output logic drive_valid,
   output logic [STAGES-1:0] parallel_out,
   output logic [STAGES-1:0] parallel_out_oe,
   output logic serial_out_rise,
   output logic serial_out_fall,
   output logic load_stall
);
   import silp_pkg::*;
   logic sclk_d_ff;
   logic [STAGES-1:0] stage_ff;
   logic [STAGES-1:0] store_ff;
   logic [STAGES-1:0] nxt_stage;
   logic [STAGES-1:0] fifo_data;
   logic [STAGES-1:0] out_ff;
   logic rise, fall, in_ready, fifo_valid, load_req;
   localparam int FW = $clog2(STAGES + 1);
   logic store_known_ff;
   logic fill_done;
   logic [STAGES-1:0] load_word;
   logic [FW-1:0] fill_cnt_ff;

   // One place for the word storage takes: the shifted word on a rise, else the stages
   function automatic logic [STAGES-1:0] load_word_f(input logic r,
         input logic [STAGES-1:0] shifted, input logic [STAGES-1:0] held);
      return r ? shifted : held;
   endfunction

   // Edge detect on the shift clock, sampled as a synchronous input
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sclk_d_ff <= 1'b0;
      end else begin
         sclk_d_ff <= shift_clock;
      end
   end
   assign rise = shift_clock && !sclk_d_ff;
   assign fall = !shift_clock && sclk_d_ff;
   assign nxt_stage = {stage_ff[STAGES-2:0], serial_in};

   // Shift stages; not reset on purpose, contents start unknown
   always_ff @(posedge clock) begin
      if (rise) begin
         stage_ff <= nxt_stage;
      end
   end

   // Rise output tracks last stage regardless of strobe or enable
   assign serial_out_rise = stage_ff[STAGES-1];

   // Fall output samples last stage on falling edge only
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         serial_out_fall <= 1'b0;
      end else if (fall) begin
         serial_out_fall <= stage_ff[STAGES-1];
      end
   end

   // Transparent storage while strobe high, follows the new stage value at once
   assign load_word = load_word_f(rise, nxt_stage, stage_ff);
   always_ff @(posedge clock) begin
      if (storage_load_strobe) begin
         store_ff <= load_word;
      end
   end

   // Storage content is unknown until its first load, so that load is always queued
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         store_known_ff <= 1'b0;
      end else if (storage_load_strobe) begin
         store_known_ff <= 1'b1;
      end
   end

   // Queue each storage change toward the drivers; flags load_stall and drops the word if drivers back up
   assign load_req = storage_load_strobe && (rise || !store_known_ff || store_ff != stage_ff);
   assign load_stall = load_req && !in_ready;
   silp_fifo #(.WIDTH(STAGES), .DEPTH(DEPTH)) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(load_req),
      .in_ready(in_ready),
      .in_data(load_word),
      .out_valid(fifo_valid),
      .out_ready(drive_ready),
      .out_data(fifo_data)
   );
   assign drive_valid = fifo_valid;

   // Output word register, updated from the queue
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         out_ff <= '0;
      end else if (fifo_valid && drive_ready) begin
         out_ff <= fifo_data;
      end
   end

   // Three-state drive: enables follow the drive enable pin
   assign parallel_out = out_ff;
   assign parallel_out_oe = {STAGES{output_drive_enable}};

   // Rises since reset, saturating at a full word; the checks below but a_shift_in, a_fall_hold, a_first_push, a_out_hold and a_oe_follow wait for it
   // because the stages are never reset and hold unknowns until then
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fill_cnt_ff <= '0;
      end else if (rise && !fill_done) begin
         fill_cnt_ff <= FW'(fill_cnt_ff + 1'b1);
      end
   end
   assign fill_done = (fill_cnt_ff == FW'(STAGES));

   // Serial input lands in stage one on every rise
   a_shift_in: assert property (@(posedge clock) disable iff (!rst_n)
      rise
      |=> stage_ff[0] == $past(serial_in))
      else $error("serial input not shifted");

   // Every stage after stage one takes its neighbour on a rise
   a_shift_chain: assert property (@(posedge clock) disable iff (!rst_n)
      fill_done && rise
      |=> stage_ff[STAGES-1:1] == $past(stage_ff[STAGES-2:0]))
      else $error("stages did not shift");

   // No rise, no shift
   a_stage_hold: assert property (@(posedge clock) disable iff (!rst_n)
      fill_done && !rise
      |=> $stable(stage_ff))
      else $error("stages moved without a rise");

   // A falling edge must not shift the stages
   a_fall_no_shift: assert property (@(posedge clock) disable iff (!rst_n)
      fill_done && fall
      |=> $stable(stage_ff))
      else $error("stages moved on a fall");

   // Rise output shows stage seven's old content after each rise
   a_rise_stage: assert property (@(posedge clock) disable iff (!rst_n)
      fill_done && $rose(shift_clock)
      |=> serial_out_rise == $past(stage_ff[STAGES-2]))
      else $error("rise output missed stage seven");

   // Rise output moves only on a rise
   a_rise_hold: assert property (@(posedge clock) disable iff (!rst_n)
      fill_done && !rise
      |=> $stable(serial_out_rise))
      else $error("rise output changed off edge");

   // Rise output still follows with strobe and drive enable both low
   a_rise_free: assert property (@(posedge clock) disable iff (!rst_n)
      fill_done && rise && !storage_load_strobe && !output_drive_enable
      |=> serial_out_rise == $past(stage_ff[STAGES-2]))
      else $error("rise output gated by strobe or enable");

   // Fall output takes stage eight on a fall
   a_fall_take: assert property (@(posedge clock) disable iff (!rst_n)
      fill_done && fall
      |=> serial_out_fall == $past(stage_ff[STAGES-1]))
      else $error("fall output wrong");

   // Fall output holds between falls
   a_fall_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !fall
      |=> $stable(serial_out_fall))
      else $error("fall output changed off edge");

   // Strobe low freezes storage, shifting or not
   a_store_hold: assert property (@(posedge clock) disable iff (!rst_n)
      fill_done && store_known_ff && !storage_load_strobe
      |=> $stable(store_ff))
      else $error("storage changed with strobe low");

   // Strobe high: storage follows the stages, new rise value included
   a_store_follow: assert property (@(posedge clock) disable iff (!rst_n)
      fill_done && storage_load_strobe
      |=> store_ff == $past(load_word))
      else $error("storage did not follow stages");

   // The first load after reset always reaches the queue
   a_first_push: assert property (@(posedge clock) disable iff (!rst_n)
      storage_load_strobe && !store_known_ff
      |-> load_req)
      else $error("first storage load not queued");

   // A popped word shows on the outputs the next cycle
   a_queue_show: assert property (@(posedge clock) disable iff (!rst_n)
      fill_done && fifo_valid && drive_ready
      |=> parallel_out == $past(fifo_data))
      else $error("queued word not shown");

   // Outputs hold unless a word is popped
   a_out_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !(fifo_valid && drive_ready)
      |=> $stable(parallel_out))
      else $error("outputs changed without load");

   // Every driver enable follows the drive enable pin
   a_oe_follow: assert property (@(posedge clock) disable iff (!rst_n)
      parallel_out_oe
      == {STAGES{output_drive_enable}})
      else $error("drive enable mismatch");

   // Main scenarios: shifting, falls, loads, refused loads, draining
   c_rise: cover property (@(posedge clock) disable iff (!rst_n) rise);
   c_fall: cover property (@(posedge clock) disable iff (!rst_n) fill_done && fall);
   c_load: cover property (@(posedge clock) disable iff (!rst_n) load_req && in_ready);
   c_stall: cover property (@(posedge clock) disable iff (!rst_n) load_stall);
   c_drain: cover property (@(posedge clock) disable iff (!rst_n) fifo_valid && drive_ready);
endmodule

/* File: shared/silp_defines.svh */
// Constants for the serial-in latched parallel-out block
`ifndef SILP_DEFINES_SVH
`define SILP_DEFINES_SVH
`define SILP_STAGES 8
`define SILP_FIFO_DEPTH 4
`define SILP_MSB 7
`endif

/* File: shared/silp_pkg.sv */
// Types for the serial-in latched parallel-out block
package silp_pkg;
   typedef logic [7:0] silp_word_t;
   typedef enum logic [1:0] {SILP_RD_IDLE, SILP_RD_HOLD} silp_rd_t;
endpackage

/* File: tb/silp_host.sv */
// Host controller model driving the serial side of the block
`timescale 1ns/1ps
module silp_host (
   input wire logic clock,
   input wire logic serial_out_rise,
   input wire logic serial_out_fall,
   output logic serial_in,
   output logic shift_clock,
   output logic storage_load_strobe
);
   // Words two downstream devices would take, fast-edge and slow-edge cascade
   logic [7:0] down_fast;
   logic [7:0] down_slow;
   initial begin
      down_fast = 8'h00;
      down_slow = 8'h00;
      serial_in = 1'b0;
      shift_clock = 1'b0;
      storage_load_strobe = 1'b0;
   end
   // Highest bit first, so it lands in the last stage; clock high and low two cycles each
   task automatic load(input logic [7:0] w);
      for (int i = 7; i >= 0; i--) begin
         @(negedge clock) serial_in = w[i];
         @(negedge clock) shift_clock = 1'b1;
         // A downstream device takes the bit standing just before this rise
         down_fast = {down_fast[6:0], serial_out_rise};
         down_slow = {down_slow[6:0], serial_out_fall};
         repeat (2) @(negedge clock);
         shift_clock = 1'b0;
      end
      // Released data line shows the inverse, not a stale bit
      serial_in = ~serial_in;
      @(negedge clock) storage_load_strobe = 1'b1;
      repeat (2) @(negedge clock);
      storage_load_strobe = 1'b0;
      repeat (2) @(negedge clock);
   endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the serial-in latched parallel-out block
`timescale 1ns/1ps
module tb_top;
   import silp_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic output_drive_enable = 1'b1;
   logic drive_ready = 1'b1;
   logic stall_seen = 1'b0;
   logic serial_in, shift_clock, storage_load_strobe;
   logic drive_valid, serial_out_rise, serial_out_fall, load_stall;
   silp_word_t parallel_out, parallel_out_oe, w, prev, shown;
   silp_word_t exp_q[$];
   int bad_count = 0;
   int checks = 0;
   always #5 clock = ~clock;
   silp_host u_host (.clock(clock), .serial_out_rise(serial_out_rise),
      .serial_out_fall(serial_out_fall), .serial_in(serial_in), .shift_clock(shift_clock),
      .storage_load_strobe(storage_load_strobe));
   silp_top u_dut (.clock(clock), .rst_n(rst_n), .serial_in(serial_in),
      .shift_clock(shift_clock), .storage_load_strobe(storage_load_strobe),
      .output_drive_enable(output_drive_enable), .drive_ready(drive_ready),
      .drive_valid(drive_valid), .parallel_out(parallel_out),
      .parallel_out_oe(parallel_out_oe), .serial_out_rise(serial_out_rise),
      .serial_out_fall(serial_out_fall), .load_stall(load_stall));
   task automatic cmp_word(input string n, input silp_word_t e, input silp_word_t g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic cmp_bit(input string n, input logic e, input logic g);
      cmp_word(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic close_out();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Stall lasts one cycle and ends at the edge that loads storage: look before that edge
   always @(posedge clock) begin
      if (load_stall === 1'b1) stall_seen <= 1'b1;
   end
   // Each new parallel value takes the oldest note; words always differ from the last
   always @(negedge clock) begin
      if (rst_n && parallel_out !== shown) begin
         shown = parallel_out;
         if (exp_q.size() > 0) cmp_word("word", exp_q.pop_front(), shown);
         else cmp_word("spare", prev, shown);
      end
   end
   initial begin
      void'($urandom(32'h77c2));
      shown = 8'h00;
      prev = 8'h00;
      repeat (12) @(negedge clock);
      rst_n = 1'b1;
      cmp_word("reset", 8'h00, parallel_out);
      // Six loads drain freely, then four fill the queue and a fifth is refused
      for (int n = 0; n < 11; n++) begin
         drive_ready = (n < 6);
         w = silp_word_t'($urandom());
         if (w == prev) w = ~w;
         if (n < 10) exp_q.push_back(w);
         if (n == 10) cmp_bit("stall", 1'b0, stall_seen);
         u_host.load(w);
         cmp_bit("rise", w[7], serial_out_rise);
         cmp_bit("fall", w[7], serial_out_fall);
         if (n > 0) cmp_word("cascade fast", prev, u_host.down_fast);
         if (n > 0) cmp_word("cascade slow", prev, u_host.down_slow);
         output_drive_enable = n[0];
         @(negedge clock) cmp_word("oe", {8{n[0]}}, parallel_out_oe);
         prev = w;
      end
      cmp_bit("stall", 1'b1, stall_seen);
      // Drain the held words under a bounded wait
      drive_ready = 1'b1;
      for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(negedge clock);
      cmp_word("drained", 8'h00, silp_word_t'(exp_q.size()));
      close_out();
   end
endmodule
